// >>> src/tap_ctrl_if.sv
// tap_ctrl_if: carries sampled test-clock events and the controller state.
// assumes: all signals live in the i_clk domain.
`timescale 1ns/100ps
interface tap_ctrl_if;
	logic                tck_rise;
	logic                tms;
	logic                trst;
	tap_pkg::tap_state_t state;
	modport fsm  (input tck_rise, input tms, input trst, output state);
	modport core (output tck_rise, output tms, output trst, input state);
endinterface : tap_ctrl_if

// >>> src/tap_fsm.sv
// tap_fsm: the sixteen-state test access port controller.
// assumes: tck_rise is a one-cycle pulse per test-clock rising edge.
`timescale 1ns/100ps
module tap_fsm (
	input  wire logic i_clk,
	input  wire logic i_rst,
	tap_ctrl_if.fsm   ctl
);
	tap_pkg::tap_state_t state_q;
	tap_pkg::tap_state_t state_d;
	wire logic           m;

	assign m = ctl.tms;
	assign ctl.state = state_q;

	// five rises with mode select high reach TLR from any state
	always_comb begin
		case (state_q)
		tap_pkg::TLR:    state_d = m ? tap_pkg::TLR    : tap_pkg::RTI;
		tap_pkg::RTI:    state_d = m ? tap_pkg::SEL_DR : tap_pkg::RTI;
		tap_pkg::SEL_DR: state_d = m ? tap_pkg::SEL_IR : tap_pkg::CAP_DR;
		tap_pkg::CAP_DR: state_d = m ? tap_pkg::EX1_DR : tap_pkg::SH_DR;
		tap_pkg::SH_DR:  state_d = m ? tap_pkg::EX1_DR : tap_pkg::SH_DR;
		tap_pkg::EX1_DR: state_d = m ? tap_pkg::UPD_DR : tap_pkg::PA_DR;
		tap_pkg::PA_DR:  state_d = m ? tap_pkg::EX2_DR : tap_pkg::PA_DR;
		tap_pkg::EX2_DR: state_d = m ? tap_pkg::UPD_DR : tap_pkg::SH_DR;
		tap_pkg::UPD_DR: state_d = m ? tap_pkg::SEL_DR : tap_pkg::RTI;
		tap_pkg::SEL_IR: state_d = m ? tap_pkg::TLR    : tap_pkg::CAP_IR;
		tap_pkg::CAP_IR: state_d = m ? tap_pkg::EX1_IR : tap_pkg::SH_IR;
		tap_pkg::SH_IR:  state_d = m ? tap_pkg::EX1_IR : tap_pkg::SH_IR;
		tap_pkg::EX1_IR: state_d = m ? tap_pkg::UPD_IR : tap_pkg::PA_IR;
		tap_pkg::PA_IR:  state_d = m ? tap_pkg::EX2_IR : tap_pkg::PA_IR;
		tap_pkg::EX2_IR: state_d = m ? tap_pkg::UPD_IR : tap_pkg::SH_IR;
		tap_pkg::UPD_IR: state_d = m ? tap_pkg::SEL_DR : tap_pkg::RTI;
		default:         state_d = tap_pkg::TLR;
		endcase
	end

	// test reset forces TLR; system reset i_rst forces it too
	always_ff @(posedge i_clk) begin
		if (i_rst || ctl.trst) begin
			state_q <= tap_pkg::TLR;
		end else if (ctl.tck_rise) begin
			state_q <= state_d;
		end
	end
endmodule : tap_fsm

// >>> src/tap_pkg.sv
// tap_pkg: constants and types of the test access port.
// assumes: used as tap_pkg::name by the port, its controller and their interface.
package tap_pkg;
	localparam int          IR_W         = 8;
	localparam int          BSR_LEN      = 391;
	localparam int          ID_W         = 32;
	localparam int          SYNC_STAGES  = 2;
	localparam logic [7:0]  OP_EXTEST    = 8'h00;
	localparam logic [7:0]  OP_SAMPLE    = 8'h01;
	localparam logic [7:0]  OP_IDCODE    = 8'h03;
	localparam logic [7:0]  OP_HIGHZ     = 8'h10;
	localparam logic [7:0]  OP_DEBUG_LO  = 8'h80;
	localparam logic [7:0]  OP_DEBUG_HI  = 8'hFE;
	localparam logic [7:0]  OP_BYPASS    = 8'hFF;
	// fixed low bits 01 as the standard port asks for on capture
	localparam logic [7:0]  IR_CAPTURE   = 8'h01;
	localparam logic [7:0]  IR_RESET     = OP_IDCODE;
	// arbitrary identity value, bit 0 set as the standard asks
	localparam logic [31:0] ID_DEFAULT   = 32'h0A5A_5001;
	localparam logic        BYPASS_CAPTURE = 1'b0;

	typedef enum logic [15:0] {
		TLR    = 16'h0001,
		RTI    = 16'h0002,
		SEL_DR = 16'h0004,
		CAP_DR = 16'h0008,
		SH_DR  = 16'h0010,
		EX1_DR = 16'h0020,
		PA_DR  = 16'h0040,
		EX2_DR = 16'h0080,
		UPD_DR = 16'h0100,
		SEL_IR = 16'h0200,
		CAP_IR = 16'h0400,
		SH_IR  = 16'h0800,
		EX1_IR = 16'h1000,
		PA_IR  = 16'h2000,
		EX2_IR = 16'h4000,
		UPD_IR = 16'h8000
	} tap_state_t;

	typedef enum logic [3:0] {
		SEL_BYPASS = 4'h1,
		SEL_BSR    = 4'h2,
		SEL_ID     = 4'h4,
		SEL_DEBUG  = 4'h8
	} dr_sel_t;
endpackage : tap_pkg

// >>> src/tap_port.sv
// tap_port: test access port with instruction decode and data registers.
// assumes: i_clk is the running master clock, several times the test clock;
// test pins and sampled device pins arrive asynchronously.
`timescale 1ns/100ps
module tap_port #(
	parameter int          BSR_LEN = tap_pkg::BSR_LEN,
	parameter logic [31:0] ID_CODE = tap_pkg::ID_DEFAULT
) (
	input  wire logic               i_clk,
	input  wire logic               i_rst,
	input  wire logic               i_tck,
	input  wire logic               i_tms,
	input  wire logic               i_tdi,
	input  wire logic               i_trst_n,
	input  wire logic               i_trace_mode_select,
	input  wire logic [BSR_LEN-1:0] i_pin_sample,
	input  wire logic               i_debug_tdo,
	output logic                    o_tdo,
	output logic                    o_tdo_oe,
	output logic [BSR_LEN-1:0]      o_bsr_drive,
	output logic                    o_extest,
	output logic                    o_highz,
	output logic                    o_tap_reset,
	output logic                    o_debug_select,
	output logic [7:0]              o_debug_ir,
	output logic                    o_debug_capture,
	output logic                    o_debug_shift,
	output logic                    o_debug_update,
	output logic                    o_debug_tdi
);
	localparam int NS = 5;

	logic [NS-1:0]      meta_q;
	logic [NS-1:0]      sync_q;
	logic               tck_prev_q;
	logic [BSR_LEN-1:0] pin_meta_q;
	logic [BSR_LEN-1:0] pin_sync_q;
	logic [7:0]         ir_sh_q;
	logic [7:0]         ir_q;
	logic [BSR_LEN-1:0] bsr_q;
	logic [BSR_LEN-1:0] bsr_upd_q;
	logic [31:0]        id_q;
	logic               byp_q;

	tap_ctrl_if tif ();

	wire logic               tck_s;
	wire logic               tms_s;
	wire logic               tdi_s;
	wire logic               trst_n_s;
	wire logic               trace_s;
	wire logic               tck_rise;
	wire logic               tck_fall;
	wire tap_pkg::dr_sel_t   sel;
	wire tap_pkg::tap_state_t st;
	wire logic               cap_dr;
	wire logic               sh_dr;
	wire logic               upd_dr;
	wire logic               sh_ir;
	wire logic               dr_tdo;
	wire logic [BSR_LEN-1:0] bsr_shifted;

	// pin order: cell n of the chain is bit BSR_LEN-n, cell 1 nearest input
	function automatic tap_pkg::dr_sel_t decode(input logic [7:0] op,
		input logic trace);
		// reserved codes fall to bypass
		decode = tap_pkg::SEL_BYPASS;
		if ((op == tap_pkg::OP_EXTEST || op == tap_pkg::OP_SAMPLE) && !trace)
			decode = tap_pkg::SEL_BSR;
		else if (op == tap_pkg::OP_IDCODE)
			decode = tap_pkg::SEL_ID;
		else if (op >= tap_pkg::OP_DEBUG_LO && op <= tap_pkg::OP_DEBUG_HI)
			decode = tap_pkg::SEL_DEBUG;
	endfunction : decode

	assign tck_s    = sync_q[0];
	assign tms_s    = sync_q[1];
	assign tdi_s    = sync_q[2];
	assign trst_n_s = sync_q[3];
	assign trace_s  = sync_q[4];
	assign tck_rise = tck_s & ~tck_prev_q;
	assign tck_fall = ~tck_s & tck_prev_q;

	assign tif.tck_rise = tck_rise;
	assign tif.tms      = tms_s;
	assign tif.trst     = ~trst_n_s;
	assign st           = tif.state;

	// HIGHZ and BYPASS reach bypass through the default
	assign sel    = decode(ir_q, trace_s);
	assign cap_dr = tck_rise && st == tap_pkg::CAP_DR;
	assign sh_dr  = tck_rise && st == tap_pkg::SH_DR;
	assign upd_dr = tck_fall && st == tap_pkg::UPD_DR;
	assign sh_ir  = tck_rise && st == tap_pkg::SH_IR;

	// input into MSB, shift toward LSB
	assign bsr_shifted = {tdi_s, bsr_q[BSR_LEN-1:1]};

	assign dr_tdo = (sel == tap_pkg::SEL_BSR)   ? bsr_q[0] :
	                (sel == tap_pkg::SEL_ID)    ? id_q[0] :
	                (sel == tap_pkg::SEL_DEBUG) ? i_debug_tdo : byp_q;

	tap_fsm u_fsm (
		.i_clk (i_clk),
		.i_rst (i_rst),
		.ctl   (tif.fsm)
	);

	// two stages before use; test pins are never read from meta_q
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			meta_q     <= '0;
			sync_q     <= '0;
			tck_prev_q <= 1'b0;
		end else begin
			meta_q     <= {i_trace_mode_select, i_trst_n, i_tdi, i_tms, i_tck};
			sync_q     <= meta_q;
			tck_prev_q <= tck_s;
		end
	end

	always_ff @(posedge i_clk) begin
		pin_meta_q <= i_pin_sample;
		pin_sync_q <= pin_meta_q;
	end

	// instruction path
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			ir_sh_q <= tap_pkg::IR_CAPTURE;
			ir_q    <= tap_pkg::IR_RESET;
		end else if (st == tap_pkg::TLR) begin
			ir_q    <= tap_pkg::IR_RESET;
		end else if (tck_rise && st == tap_pkg::CAP_IR) begin
			ir_sh_q <= tap_pkg::IR_CAPTURE;
		end else if (sh_ir) begin
			ir_sh_q <= {tdi_s, ir_sh_q[7:1]};
		end else if (tck_fall && st == tap_pkg::UPD_IR) begin
			ir_q    <= ir_sh_q;
		end
	end

	// boundary chain, one continuous register
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			bsr_q     <= '0;
			bsr_upd_q <= '0;
		end else if (sel == tap_pkg::SEL_BSR) begin
			if (cap_dr)
				bsr_q <= pin_sync_q;
			else if (sh_dr)
				bsr_q <= bsr_shifted;
			if (upd_dr)
				bsr_upd_q <= bsr_q;
		end
	end

	// identification and bypass
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			id_q  <= ID_CODE;
			byp_q <= tap_pkg::BYPASS_CAPTURE;
		end else begin
			if (cap_dr && sel == tap_pkg::SEL_ID)
				id_q <= ID_CODE;
			else if (sh_dr && sel == tap_pkg::SEL_ID)
				id_q <= {tdi_s, id_q[31:1]};
			if (cap_dr && sel == tap_pkg::SEL_BYPASS)
				byp_q <= tap_pkg::BYPASS_CAPTURE;
			else if (sh_dr && sel == tap_pkg::SEL_BYPASS)
				byp_q <= tdi_s;
		end
	end

	// serial output changes on the falling test clock, as testers expect
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			o_tdo    <= 1'b0;
			o_tdo_oe <= 1'b0;
		end else if (tck_fall) begin
			o_tdo_oe <= (st == tap_pkg::SH_DR) || (st == tap_pkg::SH_IR);
			o_tdo    <= (st == tap_pkg::SH_IR) ? ir_sh_q[0] : dr_tdo;
		end
	end

	// test modes; trace mode blocks EXTEST, but HIGHZ still applies in it
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			o_extest        <= 1'b0;
			o_highz         <= 1'b0;
			o_tap_reset     <= 1'b1;
			o_bsr_drive     <= '0;
			o_debug_select  <= 1'b0;
			o_debug_ir      <= tap_pkg::IR_RESET;
			o_debug_capture <= 1'b0;
			o_debug_shift   <= 1'b0;
			o_debug_update  <= 1'b0;
			o_debug_tdi     <= 1'b0;
		end else begin
			o_extest    <= ir_q == tap_pkg::OP_EXTEST && !trace_s;
			o_highz     <= ir_q == tap_pkg::OP_HIGHZ;
			o_tap_reset <= st == tap_pkg::TLR;
			o_bsr_drive <= bsr_upd_q;
			o_debug_select  <= sel == tap_pkg::SEL_DEBUG;
			o_debug_ir      <= ir_q;
			o_debug_capture <= cap_dr && sel == tap_pkg::SEL_DEBUG;
			o_debug_shift   <= sh_dr && sel == tap_pkg::SEL_DEBUG;
			o_debug_update  <= upd_dr && sel == tap_pkg::SEL_DEBUG;
			o_debug_tdi     <= tdi_s;
		end
	end
endmodule : tap_port

// >>> tb/tap_port_chk.sv
// tap_port_chk: decode and timing assertions on the test port.
// assumes: bound into tap_port, sees only its ports.
`timescale 1ns/100ps
module tap_port_chk (
	input  wire logic       i_clk,
	input  wire logic       i_rst,
	input  wire logic       i_tck,
	input  wire logic       i_trst_n,
	input  wire logic       i_trace_mode_select,
	input  wire logic       o_tdo_oe,
	input  wire logic       o_extest,
	input  wire logic       o_highz,
	input  wire logic       o_tap_reset,
	input  wire logic       o_debug_select,
	input  wire logic [7:0] o_debug_ir,
	input  wire logic       o_debug_update
);
	logic [7:0] ir1_q, ir2_q;
	logic [3:0] tr_q;
	logic       steady;
	// decode flags lag the opcode, so judge them once it has settled
	assign steady = ir1_q == o_debug_ir && ir2_q == o_debug_ir
		&& tr_q == {4{i_trace_mode_select}};
	always_ff @(posedge i_clk) begin
		ir1_q <= o_debug_ir;
		ir2_q <= ir1_q;
		tr_q  <= {tr_q[2:0], i_trace_mode_select};
	end
	chk_highz_flag:
	assert property (@(posedge i_clk) disable iff (i_rst)
		steady |-> o_highz == (o_debug_ir == 8'h10))
	else $error("highz flag wrong");
	chk_extest_flag:
	assert property (@(posedge i_clk) disable iff (i_rst)
		steady |-> o_extest == (o_debug_ir == 8'h00
		&& !i_trace_mode_select))
	else $error("extest flag wrong");
	chk_debug_decode:
	assert property (@(posedge i_clk) disable iff (i_rst)
		steady |-> o_debug_select == (o_debug_ir >= 8'h80
		&& o_debug_ir <= 8'hFE))
	else $error("debug select wrong");
	chk_reset_opcode:
	assert property (@(posedge i_clk) disable iff (i_rst)
		$rose(o_tap_reset) |-> ##[1:3] o_debug_ir == 8'h03)
	else $error("reset opcode not loaded");
	chk_trst_hold:
	assert property (@(posedge i_clk) disable iff (i_rst)
		!i_trst_n [*6] |-> o_tap_reset)
	else $error("test reset ignored");
	chk_oe_on_fall:
	assert property (@(posedge i_clk) disable iff (i_rst)
		$changed(o_tdo_oe) |-> !$past(i_tck, 2) && $past(i_tck, 6))
	else $error("oe moved off a falling edge");
	chk_oe_not_reset:
	assert property (@(posedge i_clk) disable iff (i_rst)
		o_tdo_oe |-> !o_tap_reset)
	else $error("oe high in reset state");
	chk_debug_pulse:
	assert property (@(posedge i_clk) disable iff (i_rst)
		o_debug_update |-> o_debug_select ##1 !o_debug_update)
	else $error("debug update pulse wrong");
endmodule : tap_port_chk
bind tap_port tap_port_chk u_chk (.i_clk, .i_rst, .i_tck, .i_trst_n,
	.i_trace_mode_select, .o_tdo_oe, .o_extest, .o_highz, .o_tap_reset,
	.o_debug_select, .o_debug_ir, .o_debug_update);

// >>> tb/tap_port_test.sv
// tap_port_test: drives the port through the tester model.
// assumes: expected tdo bits are queued before each shift.
`timescale 1ns/100ps
module tap_port_test;
	localparam logic [31:0] ID = 32'h5A3C_0F81; // arbitrary value
	logic         i_clk, i_rst, i_tck, i_tms, i_tdi, i_trst_n;
	logic         i_trace_mode_select, i_debug_tdo, seen, tbit;
	logic         o_tdo, o_tdo_oe, o_extest, o_highz, o_tap_reset;
	logic         o_debug_select, o_debug_capture, o_debug_shift;
	logic         o_debug_update, o_debug_tdi;
	logic [7:0]   o_debug_ir;
	logic [390:0] i_pin_sample, o_bsr_drive, v;
	// BYPASS, HIGHZ and reserved codes, chosen on purpose to reach the fallback
	logic [7:0]   ops[6] = '{8'hFF, 8'h10, 8'h02, 8'h05, 8'h7F, 8'h11};
	logic         q[$];
	int           num_errors = 0;
	int           checked = 0;
	int           seed;
	// debug strobes are tallied so that a missing or doubled pulse shows
	logic [7:0]   ncap = '0;
	logic [7:0]   nsh = '0;
	logic [7:0]   nupd = '0;
	logic [7:0]   dsh;
	tap_port #(.ID_CODE(ID)) DUT (.i_clk, .i_rst, .i_tck, .i_tms, .i_tdi,
		.i_trst_n, .i_trace_mode_select, .i_pin_sample, .i_debug_tdo,
		.o_tdo, .o_tdo_oe, .o_bsr_drive, .o_extest, .o_highz, .o_tap_reset,
		.o_debug_select, .o_debug_ir, .o_debug_capture, .o_debug_shift,
		.o_debug_update, .o_debug_tdi);
	// a released line reads inverted, so a late or early enable shows up
	tap_tester u_tst (.i_clk, .i_tdo(o_tdo_oe ? o_tdo : ~o_tdo),
		.o_tck(i_tck), .o_tms(i_tms), .o_tdi(i_tdi), .o_seen(seen),
		.o_bit(tbit));
	task end_of_test;
		$display("errors %0d checks %0d", num_errors, checked);
		if (num_errors == 0 && checked > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask : end_of_test
	task cmp(input logic [390:0] got, input logic [390:0] exp);
		checked++;
		if (got !== exp) begin
			num_errors++;
			$display("[ERR] %0t got %h exp %h", $time, got, exp);
		end
	endtask : cmp
	// seen spans one whole cycle, so the middle edge finds tbit settled
	always @(posedge i_clk) begin
		if (seen === 1'b1) begin
			checked++;
			if (q.size() == 0 || q[0] !== tbit) begin
				num_errors++;
				$display("[ERR] %0t serial bit mismatch", $time);
			end
			if (q.size() != 0)
				void'(q.pop_front());
		end
	end
	always @(negedge i_clk) begin
		ncap = ncap + o_debug_capture;
		nsh  = nsh + o_debug_shift;
		nupd = nupd + o_debug_update;
		if (o_debug_shift === 1'b1)
			dsh = {o_debug_tdi, dsh[7:1]};
	end
	function automatic logic [390:0] rnd;
		logic [390:0] r;
		for (int k = 0; k < 391; k++)
			r[k] = 1'($urandom);
		return r;
	endfunction : rnd
	task go(input logic ir);
		u_tst.step(1, 0, 0);
		if (ir)
			u_tst.step(1, 0, 0);
		u_tst.step(0, 0, 0);
		u_tst.step(0, 0, 0);
	endtask : go
	// last bit leaves shift, then update and back to idle
	task sh(input int n, input logic [390:0] din, input logic [390:0] exp,
		input logic chk);
		for (int i = 0; i < n; i++) begin
			if (chk)
				q.push_back(exp[i]);
			u_tst.step(i == n - 1, din[i], chk);
		end
		u_tst.step(1, 0, 0);
		u_tst.step(0, 0, 0);
	endtask : sh
	task ld(input logic [7:0] op);
		go(1);
		sh(8, op, 8'h01, 1);
		cmp(o_debug_ir, op);
	endtask : ld
	initial begin
		i_clk = 1'b0;
		forever #10 i_clk = ~i_clk;
	end
	initial begin
		repeat (60000) @(posedge i_clk);
		num_errors++;
		end_of_test;
	end
	initial begin
		seed = $urandom(32'h42A1);
		i_rst = 1'b1;
		i_trst_n = 1'b1;
		i_trace_mode_select = 1'b0;
		i_debug_tdo = 1'b1;
		i_pin_sample = rnd();
		repeat (12) @(negedge i_clk);
		i_rst = 1'b0;
		repeat (4) @(negedge i_clk);
		cmp(o_tap_reset, 1);
		cmp(o_debug_ir, 8'h03);
		u_tst.step(0, 0, 0);
		go(0);
		sh(32, 0, ID, 1);
		foreach (ops[j]) begin
			ld(ops[j]);
			cmp(o_highz, ops[j] == 8'h10);
			cmp(o_extest, 0);
			v = rnd();
			go(0);
			sh(16, v, {v[389:0], 1'b0}, 1);
		end
		ld(8'h80);
		cmp(o_debug_select, 1);
		v = rnd();
		go(0);
		sh(8, v, '1, 1);
		cmp(ncap, 1);
		cmp(nsh, 8);
		cmp(nupd, 1);
		cmp(dsh, v[7:0]);
		ld(8'h01);
		v = rnd();
		go(0);
		sh(391, v, i_pin_sample, 1);
		ld(8'h00);
		cmp(o_extest, 1);
		cmp(o_bsr_drive, v);
		i_trace_mode_select = 1'b1;
		v = rnd();
		go(0);
		sh(16, v, {v[389:0], 1'b0}, 1);
		cmp(o_extest, 0);
		repeat (5) u_tst.step(1, 0, 0);
		repeat (4) @(negedge i_clk);
		cmp(o_debug_ir, 8'h03);
		u_tst.step(0, 0, 0);
		ld(8'hFF);
		i_trst_n = 1'b0;
		repeat (8) @(negedge i_clk);
		cmp(o_tap_reset, 1);
		i_trst_n = 1'b1;
		end_of_test;
	end
endmodule : tap_port_test

// >>> tb/tap_tester.sv
// tap_tester: behavioural boundary-scan tester on the serial pins.
// assumes: test clock stands low between steps, 8 master cycles each.
`timescale 1ns/100ps
module tap_tester (
	input  wire logic i_clk,
	input  wire logic i_tdo,
	output logic      o_tck,
	output logic      o_tms,
	output logic      o_tdi,
	output logic      o_seen,
	output logic      o_bit
);
	initial begin
		o_tck = 1'b0;
		o_tms = 1'b1;
		o_tdi = 1'b0;
		o_seen = 1'b0;
		o_bit = 1'b0;
	end
	// tdo is taken late in the high phase, well after it settled
	task step(input logic tms, input logic tdi, input logic chk);
		o_tms = tms;
		o_tdi = tdi;
		repeat (4) @(negedge i_clk);
		o_tck = 1'b1;
		repeat (3) @(negedge i_clk);
		o_bit = i_tdo;
		o_seen = chk;
		@(negedge i_clk);
		o_seen = 1'b0;
		o_tck = 1'b0;
	endtask : step
endmodule : tap_tester
